//--- hdl/ldsc_core.sv
/*
  Fault detection, clear-on-read fault register, periodic open-load schedule
  and sense selection for two high-side channels. Assumes comparator and
  input pins are synchronous to clk_i, and register access over a plain port.
*/
`timescale 1ns/10ps
`include "ldsc_defines.svh"

module ldsc_core #(
  parameter int unsigned OLLED_CYC = `LDSC_OLLED_CYC,
  parameter int unsigned SNS_W = 8
) (
  input wire logic clk_i, // device clock
  input wire logic rst_n_i, // sync reset, active low
  input wire logic [3:0] addr_i, // register index
  input wire ldsc_pkg::ldsc_word_t wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output ldsc_pkg::ldsc_word_t rdata_o, // read data, cycle after rd_i
  input wire logic [1:0] dir_in_i, // direct inputs
  input wire logic [1:0] pwm_on_i, // internal pwm on request
  input wire logic [1:0] out_hi_short_i, // output above short threshold
  input wire logic [1:0] out_hi_open_i, // output above open-load threshold
  input wire logic [1:0] load_low_i, // current below open-load-on threshold
  input wire logic [1:0] oc_window_i, // overcurrent window active
  input wire logic [SNS_W-1:0] cur0_i, // channel 0 mirrored current
  input wire logic [SNS_W-1:0] cur1_i, // channel 1 mirrored current
  input wire logic [SNS_W-1:0] temp_i, // temperature value
  output logic [1:0] ch_on_o, // channel gate command
  output logic [1:0] oc_low_thr_o, // lowered overcurrent thresholds
  output logic fault_status_pin_o, // low while a fault is present
  output logic sense_valid_pin_n_o, // low while sense is valid
  output logic [SNS_W-1:0] sense_o // sense output value
);
  import ldsc_pkg::*;

  ldsc_word_t conf_q [2];
  ldsc_word_t gcr_q;
  ldsc_word_t ocr_q;
  logic [5:0] fault_q;
  ldsc_word_t rdata_q;
  logic [1:0] on_q;
  logic [1:0] chk_pend_q;
  logic [31:0] olled_cnt_q [2];
  logic [4:0] settle_q;
  logic valid_q;
  logic [SNS_W-1:0] hold_q;
  logic hold_ok_q;

  wire fault_rd = rd_i && (addr_i == `LDSC_OFS_FAULT);
  wire th_en = gcr_q[`LDSC_GCR_TH_EN];
  wire ldsc_sns_e sns_sel = ldsc_sns_e'({gcr_q[`LDSC_GCR_SNS1], gcr_q[`LDSC_GCR_SNS0]});
  wire [1:0] low_ratio = {ocr_q[`LDSC_OCR_LOW_RATIO1], ocr_q[`LDSC_OCR_LOW_RATIO0]};
  logic [1:0] os_live;
  logic [1:0] open_load_while_off_live;
  logic [1:0] open_load_while_on_live;
  logic [1:0] ch_on;
  logic [1:0] turn_off;
  logic [1:0] open_load_while_on_evt;
  logic [1:0] open_load_while_on_clean;

  assign oc_low_thr_o = low_ratio;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      wire dir_dis = conf_q[g][`LDSC_CONF_DIR_DIS];
      wire int_pwm = dir_dis || conf_q[g][`LDSC_CONF_SW_ON];
      assign ch_on[g] = int_pwm ? pwm_on_i[g] : dir_in_i[g];
      assign turn_off[g] = on_q[g] && !ch_on[g];
      assign os_live[g] = !ch_on[g] && out_hi_short_i[g] && !conf_q[g][`LDSC_CONF_OS_DIS];
      // off open load every off period
      assign open_load_while_off_live[g] = !ch_on[g] && out_hi_open_i[g] && !conf_q[g][`LDSC_CONF_OPEN_LOAD_WHILE_OFF_DIS];
      // low ratio check needs fast slew; periodic with internal pwm, at every turn-off with direct input
      wire lr_ok = conf_q[g][`LDSC_CONF_FAST_SLEW] && !conf_q[g][`LDSC_CONF_ON_OPEN_LOAD_DISABLE];
      // internal pwm: first turn-off after interval, or first cycle still on after it, at any duty
      wire per_evt = chk_pend_q[g] && (turn_off[g] || (on_q[g] && ch_on[g]));
      // duty limit of 85% is met by the input source
      wire lr_evt = lr_ok && (int_pwm ? per_evt : turn_off[g]);
      assign open_load_while_on_evt[g] = lr_evt;
      assign open_load_while_on_clean[g] = lr_evt && !load_low_i[g];
      assign open_load_while_on_live[g] = low_ratio[g] ? (lr_evt && load_low_i[g])
                          : (ch_on[g] && load_low_i[g] && !conf_q[g][`LDSC_CONF_ON_OPEN_LOAD_DISABLE]);
    end
  endgenerate

  // channel command never gated by diagnostics
  assign ch_on_o = on_q;

  wire fs_d = !(|os_live || |open_load_while_off_live || |(load_low_i & on_q & ~low_ratio &
                ~{conf_q[1][`LDSC_CONF_ON_OPEN_LOAD_DISABLE], conf_q[0][`LDSC_CONF_ON_OPEN_LOAD_DISABLE]}) || |open_load_while_on_live);

  // fault bits: [1:0] short, [3:2] off open load, [5:4] on open load
  logic [5:0] fault_clr;
  logic [1:0] lr_clean_q;
  always_comb begin
    fault_clr = 6'h00;
    if (fault_rd) begin
      fault_clr[3:0] = 4'hF;
      for (int i = 0; i < 2; i++) begin
        if (low_ratio[i])
          fault_clr[4+i] = lr_clean_q[i];
        else
          fault_clr[4+i] = !on_q[i] || !load_low_i[i];
      end
    end
  end

  wire [5:0] fault_set = {open_load_while_on_live, open_load_while_off_live, os_live};
  wire [5:0] fault_d = (fault_q & ~fault_clr) | fault_set;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lr_clean_q <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (open_load_while_on_evt[i])
          lr_clean_q[i] <= open_load_while_on_clean[i];
        else if (fault_rd)
          lr_clean_q[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      chk_pend_q <= 2'b00;
      olled_cnt_q[0] <= 32'h0;
      olled_cnt_q[1] <= 32'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (open_load_while_on_evt[i]) begin
          chk_pend_q[i] <= 1'b0;
          olled_cnt_q[i] <= 32'h0;
        end else if (olled_cnt_q[i] >= OLLED_CYC - 1) begin
          chk_pend_q[i] <= 1'b1;
        end else begin
          olled_cnt_q[i] <= olled_cnt_q[i] + 32'h1;
        end
      end
    end
  end

  // register port
  wire wr_conf0 = wr_i && (addr_i == `LDSC_OFS_CONF0);
  wire wr_conf1 = wr_i && (addr_i == `LDSC_OFS_CONF1);
  wire wr_gcr = wr_i && (addr_i == `LDSC_OFS_GCR);
  wire wr_ocr = wr_i && (addr_i == `LDSC_OFS_OCR);
  ldsc_word_t rd_mux;
  always_comb begin
    unique case (addr_i)
      `LDSC_OFS_CONF0: rd_mux = conf_q[0];
      `LDSC_OFS_CONF1: rd_mux = conf_q[1];
      `LDSC_OFS_GCR: rd_mux = gcr_q;
      `LDSC_OFS_OCR: rd_mux = ocr_q;
      `LDSC_OFS_FAULT: rd_mux = {10'h000, fault_q};
      `LDSC_OFS_STAT: rd_mux = {12'h000, valid_q, fault_status_pin_o, on_q};
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      conf_q[0] <= `LDSC_CONF_RST;
      conf_q[1] <= `LDSC_CONF_RST;
      gcr_q <= `LDSC_GCR_RST;
      ocr_q <= `LDSC_OCR_RST;
      fault_q <= 6'h00;
      rdata_q <= 16'h0000;
      on_q <= 2'b00;
      fault_status_pin_o <= 1'b1;
    end else begin
      if (wr_conf0)
        conf_q[0] <= wdata_i;
      if (wr_conf1)
        conf_q[1] <= wdata_i;
      if (wr_gcr)
        gcr_q <= wdata_i;
      if (wr_ocr)
        ocr_q <= wdata_i;
      fault_q <= fault_d;
      rdata_q <= rd_i ? rd_mux : 16'h0000;
      on_q <= ch_on;
      fault_status_pin_o <= fs_d;
    end
  end
  assign rdata_o = rdata_q;

  // sense path on selected channel
  wire sel_ch = (sns_sel == LDSC_SNS_CH1);
  wire is_cur = (sns_sel == LDSC_SNS_CH0) || (sns_sel == LDSC_SNS_CH1);
  wire sel_on = on_q[sel_ch];
  wire sel_off_evt = turn_off[sel_ch];
  wire oc_act = |oc_window_i;
  wire [SNS_W-1:0] cur_sel = sel_ch ? cur1_i : cur0_i;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      settle_q <= 5'h00;
      valid_q <= 1'b0;
      hold_q <= '0;
      hold_ok_q <= 1'b0;
    end else begin
      if (!is_cur || oc_act || !sel_on) begin
        settle_q <= 5'h00;
        valid_q <= 1'b0;
      end else if (settle_q < 5'(`LDSC_SETTLE_CYC)) begin
        settle_q <= settle_q + 5'h01;
      end else begin
        valid_q <= 1'b1;
      end
      if (is_cur && sel_off_evt && valid_q) begin
        hold_q <= cur_sel;
        hold_ok_q <= 1'b1;
      end else if (!is_cur || oc_act) begin
        hold_ok_q <= 1'b0;
      end
    end
  end

  // valid pin low only in settled on time
  assign sense_valid_pin_n_o = !(valid_q && sel_on && !oc_act && is_cur);

  logic [SNS_W-1:0] sns_out;
  always_comb begin
    sns_out = '0;
    if (sns_sel == LDSC_SNS_TEMP)
      sns_out = temp_i;
    else if (is_cur && !oc_act) begin
      if (sel_on)
        sns_out = cur_sel;
      else if (th_en && hold_ok_q)
        sns_out = hold_q;
    end
  end

  logic [SNS_W-1:0] sense_q;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i)
      sense_q <= '0;
    else
      sense_q <= sns_out;
  end
  assign sense_o = sense_q;
endmodule

//--- hdl/ldsc_defines.svh
/*
  Offsets, field positions, reset values and timing counts for the load
  diagnostic and sense control block. Assumes a 50 MHz device clock.
*/
`ifndef LDSC_DEFINES_SVH
`define LDSC_DEFINES_SVH

`define LDSC_CLK_HZ 50000000
// register offsets (word index on the plain port)
`define LDSC_OFS_CONF0 4'h0
`define LDSC_OFS_CONF1 4'h1
`define LDSC_OFS_GCR 4'h2
`define LDSC_OFS_OCR 4'h3
`define LDSC_OFS_FAULT 4'h4
`define LDSC_OFS_STAT 4'h5
// channel config fields
`define LDSC_CONF_ON_OPEN_LOAD_DISABLE 8
`define LDSC_CONF_OPEN_LOAD_WHILE_OFF_DIS 7
`define LDSC_CONF_OS_DIS 6
`define LDSC_CONF_DIR_DIS 5
`define LDSC_CONF_FAST_SLEW 4
`define LDSC_CONF_SW_ON 3
`define LDSC_CONF_RST 16'h0000
// general config fields
`define LDSC_GCR_SNS0 0
`define LDSC_GCR_SNS1 1
`define LDSC_GCR_TH_EN 2
`define LDSC_GCR_RST 16'h0000
// overcurrent config fields
`define LDSC_OCR_LOW_RATIO0 0
`define LDSC_OCR_LOW_RATIO1 1
`define LDSC_OCR_RST 16'h0000
// periodic open-load interval and sense settle count
`define LDSC_OLLED_MS 150
`define LDSC_OLLED_CYC ((`LDSC_CLK_HZ / 1000) * `LDSC_OLLED_MS)
`define LDSC_SETTLE_CYC 16

`endif

//--- hdl/ldsc_pkg.sv
/*
  Types for the load diagnostic and sense control block.
  Assumes ldsc_defines.svh supplies the numbers.
*/
package ldsc_pkg;
  typedef enum logic [1:0] {
    LDSC_SNS_OFF = 2'b00,
    LDSC_SNS_CH0 = 2'b01,
    LDSC_SNS_CH1 = 2'b10,
    LDSC_SNS_TEMP = 2'b11
  } ldsc_sns_e;
  typedef logic [15:0] ldsc_word_t;
endpackage

//--- tb/ldsc_load_model.sv
/* load and comparator model for channel 0
   assumes mode 0 good load, 1 open load, 2 shorted to supply */
`timescale 1ns/10ps
module ldsc_load_model (
  input wire logic ch_on_i, // channel gate
  input wire logic [1:0] mode_i, // load state
  output logic short_o, // above short threshold
  output logic open_o, // above open threshold
  output logic low_o // current below threshold
);
  assign short_o = !ch_on_i && mode_i == 2'h2;
  assign open_o = !ch_on_i && mode_i == 2'h1;
  assign low_o = ch_on_i && mode_i == 2'h1;
endmodule

//--- tb/ldsc_core_sva.sv
/* checker on the ldsc_core ports, bound below
   assumes channel 1 sees no faults */
`timescale 1ns/10ps
module ldsc_chk (
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // reset
  input wire logic [3:0] addr_i, // index
  input wire ldsc_pkg::ldsc_word_t wdata_i, // write data
  input wire logic wr_i, // write
  input wire logic [1:0] dir_in_i, // direct in
  input wire logic [1:0] out_hi_short_i, // short cmp
  input wire logic [1:0] out_hi_open_i, // open cmp
  input wire logic [1:0] load_low_i, // low current
  input wire logic [1:0] oc_window_i, // oc window
  input wire logic [1:0] ch_on_o, // gate
  input wire logic [1:0] oc_low_thr_o, // thresholds
  input wire logic fault_status_pin_o, // fault pin
  input wire logic sense_valid_pin_n_o // valid pin
);
  import ldsc_pkg::*;
  logic [8:0] conf_q;
  logic low_q;
  // shadow of channel 0 config and ratio
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      conf_q <= 9'h000;
      low_q <= 1'b0;
    end else if (wr_i && addr_i == 4'h0) begin
      conf_q <= wdata_i[8:0];
    end else if (wr_i && addr_i == 4'h3) begin
      low_q <= wdata_i[0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence quiet_s;
    (out_hi_short_i == 2'h0 && out_hi_open_i == 2'h0 && load_low_i == 2'h0) [*2];
  endsequence
  thr_copy_a: assert property (wr_i && addr_i == 4'h3 |=> oc_low_thr_o == $past(wdata_i[1:0]))
    else $error("threshold select wrong");
  dir_follow_a: assert property (!conf_q[5] && !conf_q[3] |=> ch_on_o[0] == $past(dir_in_i[0]))
    else $error("channel does not follow input");
  short_pin_a: assert property ((!conf_q[6] && !conf_q[5] && !conf_q[3] && !ch_on_o[0] && !dir_in_i[0]
    && out_hi_short_i[0]) [*2] |=> !fault_status_pin_o) else $error("short not shown");
  open_pin_a: assert property ((!conf_q[7] && !conf_q[5] && !conf_q[3] && !ch_on_o[0] && !dir_in_i[0]
    && out_hi_open_i[0]) [*2] |=> !fault_status_pin_o) else $error("off open load not shown");
  on_open_a: assert property ((!conf_q[8] && !low_q && ch_on_o[0] && load_low_i[0]) [*2]
    |=> !fault_status_pin_o) else $error("on open load not shown");
  pin_clear_a: assert property (quiet_s |=> fault_status_pin_o)
    else $error("fault pin stuck low");
  oc_valid_a: assert property ((oc_window_i == 2'h3) [*2] |-> sense_valid_pin_n_o)
    else $error("valid during oc window");
  off_valid_a: assert property ((ch_on_o == 2'h0) [*2] |-> sense_valid_pin_n_o)
    else $error("valid while off");
endmodule

bind ldsc_core ldsc_chk chk (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .dir_in_i, .out_hi_short_i,
  .out_hi_open_i, .load_low_i, .oc_window_i, .ch_on_o, .oc_low_thr_o, .fault_status_pin_o, .sense_valid_pin_n_o);

//--- tb/tb_top.sv
/* self-checking bench for ldsc_core with a channel 0 load model
   assumes the checker binds itself */
`timescale 1ns/10ps
module tb_top;
  import ldsc_pkg::*;
  logic clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, rd_q = 1'b0;
  logic fault_status_pin_o, sense_valid_pin_n_o;
  logic [3:0] addr_i = 4'h0;
  ldsc_word_t wdata_i = 16'h0000, rdata_o, exp_q[$];
  logic [1:0] dir_in_i = 2'h0, pwm_on_i = 2'h0, oc_window_i = 2'h0, mode = 2'h0;
  logic [1:0] ch_on_o, oc_low_thr_o, out_hi_short_i, out_hi_open_i, load_low_i;
  logic [7:0] cur0_i = 8'h00, temp_i = 8'h00, held, sense_o;
  logic [31:0] seed = 32'h4EB9555A;
  int num_errors = 0, samples_checked = 0, cycles = 0;
  ldsc_core #(.OLLED_CYC(100), .SNS_W(8)) dut (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .dir_in_i, .pwm_on_i, .out_hi_short_i, .out_hi_open_i, .load_low_i, .oc_window_i, .cur0_i, .cur1_i(8'h00),
    .temp_i, .ch_on_o, .oc_low_thr_o, .fault_status_pin_o, .sense_valid_pin_n_o, .sense_o);
  ldsc_load_model model (.ch_on_i(ch_on_o[0]), .mode_i(mode), .short_o(out_hi_short_i[0]),
    .open_o(out_hi_open_i[0]), .low_o(load_low_i[0]));
  assign {out_hi_short_i[1], out_hi_open_i[1], load_low_i[1]} = 3'h0;
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input ldsc_word_t d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    tick(1);
    wr_i <= 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [3:0] a, input ldsc_word_t e);
    exp_q.push_back(e);
    addr_i <= a;
    rd_i <= 1'b1;
    tick(1);
    rd_i <= 1'b0;
    tick(1);
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    rd_q <= rd_i;
    cycles <= cycles + 1;
    if (rd_q) begin
      chk(rdata_o, exp_q.pop_front());
    end
    if (cycles == 3000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    tick(12);
    rst_n_i <= 1'b1;
    tick(1);
    for (int i = 0; i < 5; i++) begin
      rd(4'(i), 16'h0000);
    end
    wr(4'hF, 16'hFFFF);
    wr(4'h4, 16'hFFFF);
    rd(4'hF, 16'h0000);
    rd(4'h4, 16'h0000);
    wr(4'h0, 16'h01F8);
    rd(4'h0, 16'h01F8);
    for (int d = 0; d < 2; d++) begin
      wr(4'h0, d == 1 ? 16'h01C0 : 16'h0000);
      for (int m = 2; m > 0; m--) begin
        mode <= 2'(m);
        tick(4);
        chk(fault_status_pin_o, 16'(d));
        mode <= 2'h0;
        tick(3);
        chk(fault_status_pin_o, 16'h0001);
        rd(4'h4, d == 1 ? 16'h0000 : (m == 2 ? 16'h0001 : 16'h0004));
        rd(4'h4, 16'h0000);
      end
    end
    wr(4'h0, 16'h0080);
    dir_in_i <= 2'h1;
    tick(3);
    mode <= 2'h1;
    tick(4);
    chk(fault_status_pin_o, 16'h0000);
    chk(16'(ch_on_o), 16'h0001);
    rd(4'h4, 16'h0010);
    rd(4'h4, 16'h0010);
    mode <= 2'h0;
    tick(3);
    rd(4'h4, 16'h0010);
    rd(4'h4, 16'h0000);
    mode <= 2'h1;
    tick(4);
    dir_in_i <= 2'h0;
    tick(3);
    rd(4'h4, 16'h0010);
    rd(4'h4, 16'h0000);
    wr(4'h3, 16'h0001);
    wr(4'h0, 16'h0098);
    pwm_on_i <= 2'h1;
    tick(130);
    chk(16'(oc_low_thr_o), 16'h0001);
    rd(4'h4, 16'h0010);
    mode <= 2'h0;
    rd(4'h4, 16'h0010);
    tick(130);
    rd(4'h4, 16'h0010);
    rd(4'h4, 16'h0000);
    pwm_on_i <= 2'h0;
    wr(4'h3, 16'h0000);
    wr(4'h0, 16'h0000);
    wr(4'h2, 16'h0001);
    cur0_i <= 8'(rnd());
    dir_in_i <= 2'h1;
    tick(20);
    chk(sense_valid_pin_n_o, 16'h0000);
    chk(16'(sense_o), 16'(cur0_i));
    oc_window_i <= 2'h3;
    tick(3);
    chk(sense_valid_pin_n_o, 16'h0001);
    oc_window_i <= 2'h0;
    wr(4'h2, 16'h0005);
    tick(20);
    held = cur0_i;
    dir_in_i <= 2'h0;
    tick(3);
    cur0_i <= 8'(rnd());
    tick(2);
    chk(sense_valid_pin_n_o, 16'h0001);
    chk(16'(sense_o), 16'(held));
    wr(4'h2, 16'h0003);
    temp_i <= 8'(rnd());
    tick(4);
    chk(16'(sense_o), 16'(temp_i));
    end_of_test();
  end
endmodule
